// ==== irqfe_map.vh ====
`ifndef IRQFE_MAP_VH
`define IRQFE_MAP_VH

// byte offsets on the register bus, one aligned 32-bit word each
`define IRQFE_OFF_FLAGS_0     6'h00
`define IRQFE_OFF_FLAGS_1     6'h04
`define IRQFE_OFF_FLAGS_2     6'h08
`define IRQFE_OFF_FLAGS_3     6'h0c
`define IRQFE_OFF_FLAGS_4     6'h10
`define IRQFE_OFF_ENABLES_0   6'h14
`define IRQFE_OFF_IRQ_STATUS  6'h18
`define IRQFE_OFF_IRQ_MASK    6'h1c

// widths
`define IRQFE_REG_W           16
`define IRQFE_FLAGS0_W        3
`define IRQFE_EVT_W           5

// implemented bits of each register
`define IRQFE_IMPL_FLAGS_0    16'h0007
`define IRQFE_IMPL_FLAGS_1    16'hffdf
`define IRQFE_IMPL_FLAGS_2    16'h601f
`define IRQFE_IMPL_FLAGS_3    16'hfe00
`define IRQFE_IMPL_FLAGS_4    16'hce7e
`define IRQFE_IMPL_ENABLES_0  16'h7fff

// reset values
`define IRQFE_RST_REG         16'h0000
`define IRQFE_RST_EVT         5'h00

// field positions of flags 0 low bits
`define IRQFE_BIT_EXT_IRQ0    0
`define IRQFE_BIT_IN_CAP1     1
`define IRQFE_BIT_OUT_CMP1    2

// event bits of the interrupt status register
`define IRQFE_EVT_FLAGS_0     0
`define IRQFE_EVT_FLAGS_1     1
`define IRQFE_EVT_FLAGS_2     2
`define IRQFE_EVT_FLAGS_3     3
`define IRQFE_EVT_FLAGS_4     4

`endif

// ==== irqfe_sync.v ====
module irqfe_sync #(
  parameter WIDTH = 1
) (
  input  wire             mclk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;

endmodule // irqfe_sync

// ==== irqfe_reg.v ====
module irqfe_reg #(
  parameter             WIDTH     = 16,
  parameter [WIDTH-1:0] IMPL_MASK = {WIDTH{1'b1}}
) (
  input  wire             mclk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] wr_mask_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire [WIDTH-1:0] hw_set_in,
  output wire [WIDTH-1:0] value_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      if (IMPL_MASK[i]) begin : g_impl
        reg bit_reg;
        // hardware set beats a software write of zero
        always @(posedge mclk_in or negedge rst_b_in) begin
          if (!rst_b_in) begin
            bit_reg <= 1'b0;
          end else begin
            bit_reg <= hw_set_in[i] | (wr_mask_in[i] ? wr_data_in[i] : bit_reg);
          end
        end
        assign value_out[i] = bit_reg;
      end else begin : g_unimpl
        // no storage: reads zero, writes fall away
        assign value_out[i] = 1'b0;
      end
    end
  endgenerate

endmodule // irqfe_reg

// ==== irqfe_bank.v ====
// Added by the designer: the Avalon-MM register port and the register offsets.
`include "irqfe_map.vh"

// Overview of operation
// - flag reads 1 once its source requested
// - enable bit 1 permits, 0 blocks request (only bits 2-0 used; bits 14-3 gate nothing)
// - unimplemented bits read zero, ignore writes
// - power-on reset clears all flags, enables
// - software reads and writes every implemented bit
// - flags 0: out compare1, capture1, ext irq0
// - flags 1 upper byte source assignment
// - flags 1 lower byte, bit 5 unimplemented
// - flags 2: bits 14,13 and 4-0 only
// - flags 3: bits 15-9 only
// - flags 4: bits 15,14,11-9,6-1 only
// - enables 0: bits 14-0, bit 15 unimplemented
module irqfe_bank (
  input  wire                         mclk_in,
  input  wire                         rst_b_in,
  input  wire [5:0]                   avs_address_in,
  input  wire                         avs_read_in,
  input  wire                         avs_write_in,
  input  wire [31:0]                  avs_writedata_in,
  input  wire [3:0]                   avs_byteenable_in,
  output wire [31:0]                  avs_readdata_out,
  output wire                         avs_waitrequest_out,
  output wire                         irq_out,
  input  wire [`IRQFE_FLAGS0_W-1:0]   src_flags0_req_in,
  input  wire [`IRQFE_REG_W-1:0]      src_flags1_req_in,
  input  wire [`IRQFE_REG_W-1:0]      src_flags2_req_in,
  input  wire [`IRQFE_REG_W-1:0]      src_flags3_req_in,
  input  wire [`IRQFE_REG_W-1:0]      src_flags4_req_in,
  output wire [`IRQFE_REG_W-1:0]      irq_flags_0_out,
  output wire [`IRQFE_REG_W-1:0]      irq_flags_1_out,
  output wire [`IRQFE_REG_W-1:0]      irq_flags_2_out,
  output wire [`IRQFE_REG_W-1:0]      irq_flags_3_out,
  output wire [`IRQFE_REG_W-1:0]      irq_flags_4_out,
  output wire [`IRQFE_REG_W-1:0]      irq_enables_0_out,
  output wire [`IRQFE_FLAGS0_W-1:0]   flags0_request_out
);

  localparam REQ_W = `IRQFE_FLAGS0_W + 4 * `IRQFE_REG_W;

  // request lines: synchronised, then rising edge makes a set pulse
  wire [REQ_W-1:0]             req_raw;
  wire [REQ_W-1:0]             req_sync;
  reg  [REQ_W-1:0]             req_prev_reg;
  wire [REQ_W-1:0]             req_rise;

  wire [`IRQFE_REG_W-1:0]      set_flags_0;
  wire [`IRQFE_REG_W-1:0]      set_flags_1;
  wire [`IRQFE_REG_W-1:0]      set_flags_2;
  wire [`IRQFE_REG_W-1:0]      set_flags_3;
  wire [`IRQFE_REG_W-1:0]      set_flags_4;

  // bus side
  reg                          waitreq_reg;
  reg  [31:0]                  readdata_reg;
  reg  [31:0]                  readdata_next;
  wire                         bus_req;
  wire                         bus_take;
  wire                         wr_take;
  wire                         rd_take;
  wire [`IRQFE_REG_W-1:0]      lane_mask;

  wire                         hit_flags_0;
  wire                         hit_flags_1;
  wire                         hit_flags_2;
  wire                         hit_flags_3;
  wire                         hit_flags_4;
  wire                         hit_enables_0;
  wire                         hit_irq_status;
  wire                         hit_irq_mask;

  wire [`IRQFE_REG_W-1:0]      flags_0_val;
  wire [`IRQFE_REG_W-1:0]      flags_1_val;
  wire [`IRQFE_REG_W-1:0]      flags_2_val;
  wire [`IRQFE_REG_W-1:0]      flags_3_val;
  wire [`IRQFE_REG_W-1:0]      flags_4_val;
  wire [`IRQFE_REG_W-1:0]      enables_0_val;

  // block interrupt
  reg  [`IRQFE_EVT_W-1:0]      irq_status_reg;
  reg  [`IRQFE_EVT_W-1:0]      irq_status_next;
  reg  [`IRQFE_EVT_W-1:0]      irq_mask_reg;
  reg  [`IRQFE_EVT_W-1:0]      irq_mask_next;
  reg                          irq_reg;
  wire [`IRQFE_EVT_W-1:0]      evt_set;

  reg  [`IRQFE_FLAGS0_W-1:0]   request_reg;

  assign req_raw = {src_flags4_req_in, src_flags3_req_in, src_flags2_req_in,
                    src_flags1_req_in, src_flags0_req_in};

  irqfe_sync #(
    .WIDTH (REQ_W)
  ) u_req_sync (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (req_raw),
    .q_out    (req_sync)
  );

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_prev_reg <= {REQ_W{1'b0}};
    end else begin
      req_prev_reg <= req_sync;
    end
  end

  // a held request line sets its flag once; software may clear it after
  assign req_rise = req_sync & ~req_prev_reg;

  assign set_flags_0 = {13'h0000, req_rise[`IRQFE_FLAGS0_W-1:0]};
  assign set_flags_1 = req_rise[`IRQFE_FLAGS0_W +: `IRQFE_REG_W];
  assign set_flags_2 = req_rise[`IRQFE_FLAGS0_W + `IRQFE_REG_W +: `IRQFE_REG_W];
  assign set_flags_3 = req_rise[`IRQFE_FLAGS0_W + 2 * `IRQFE_REG_W +: `IRQFE_REG_W];
  assign set_flags_4 = req_rise[`IRQFE_FLAGS0_W + 3 * `IRQFE_REG_W +: `IRQFE_REG_W];

  // one wait state: waitrequest drops for one cycle, the taking edge follows
  assign bus_req  = avs_read_in | avs_write_in;
  assign bus_take = bus_req & ~waitreq_reg;
  assign wr_take  = avs_write_in & ~waitreq_reg;
  assign rd_take  = avs_read_in & ~waitreq_reg;

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= ~(bus_req & waitreq_reg);
    end
  end

  assign hit_flags_0    = (avs_address_in == `IRQFE_OFF_FLAGS_0);
  assign hit_flags_1    = (avs_address_in == `IRQFE_OFF_FLAGS_1);
  assign hit_flags_2    = (avs_address_in == `IRQFE_OFF_FLAGS_2);
  assign hit_flags_3    = (avs_address_in == `IRQFE_OFF_FLAGS_3);
  assign hit_flags_4    = (avs_address_in == `IRQFE_OFF_FLAGS_4);
  assign hit_enables_0  = (avs_address_in == `IRQFE_OFF_ENABLES_0);
  assign hit_irq_status = (avs_address_in == `IRQFE_OFF_IRQ_STATUS);
  assign hit_irq_mask   = (avs_address_in == `IRQFE_OFF_IRQ_MASK);

  // upper byte lanes carry no storage
  assign lane_mask = {{8{avs_byteenable_in[1] & wr_take}},
                      {8{avs_byteenable_in[0] & wr_take}}};

  irqfe_reg #(
    .WIDTH     (`IRQFE_REG_W),
    .IMPL_MASK (`IRQFE_IMPL_FLAGS_0)
  ) u_flags_0 (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .wr_mask_in (lane_mask & {`IRQFE_REG_W{hit_flags_0}}),
    .wr_data_in (avs_writedata_in[`IRQFE_REG_W-1:0]),
    .hw_set_in  (set_flags_0),
    .value_out  (flags_0_val)
  );

  irqfe_reg #(
    .WIDTH     (`IRQFE_REG_W),
    .IMPL_MASK (`IRQFE_IMPL_FLAGS_1)
  ) u_flags_1 (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .wr_mask_in (lane_mask & {`IRQFE_REG_W{hit_flags_1}}),
    .wr_data_in (avs_writedata_in[`IRQFE_REG_W-1:0]),
    .hw_set_in  (set_flags_1),
    .value_out  (flags_1_val)
  );

  irqfe_reg #(
    .WIDTH     (`IRQFE_REG_W),
    .IMPL_MASK (`IRQFE_IMPL_FLAGS_2)
  ) u_flags_2 (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .wr_mask_in (lane_mask & {`IRQFE_REG_W{hit_flags_2}}),
    .wr_data_in (avs_writedata_in[`IRQFE_REG_W-1:0]),
    .hw_set_in  (set_flags_2),
    .value_out  (flags_2_val)
  );

  irqfe_reg #(
    .WIDTH     (`IRQFE_REG_W),
    .IMPL_MASK (`IRQFE_IMPL_FLAGS_3)
  ) u_flags_3 (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .wr_mask_in (lane_mask & {`IRQFE_REG_W{hit_flags_3}}),
    .wr_data_in (avs_writedata_in[`IRQFE_REG_W-1:0]),
    .hw_set_in  (set_flags_3),
    .value_out  (flags_3_val)
  );

  irqfe_reg #(
    .WIDTH     (`IRQFE_REG_W),
    .IMPL_MASK (`IRQFE_IMPL_FLAGS_4)
  ) u_flags_4 (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .wr_mask_in (lane_mask & {`IRQFE_REG_W{hit_flags_4}}),
    .wr_data_in (avs_writedata_in[`IRQFE_REG_W-1:0]),
    .hw_set_in  (set_flags_4),
    .value_out  (flags_4_val)
  );

  // enables have no hardware setter
  irqfe_reg #(
    .WIDTH     (`IRQFE_REG_W),
    .IMPL_MASK (`IRQFE_IMPL_ENABLES_0)
  ) u_enables_0 (
    .mclk_in    (mclk_in),
    .rst_b_in   (rst_b_in),
    .wr_mask_in (lane_mask & {`IRQFE_REG_W{hit_enables_0}}),
    .wr_data_in (avs_writedata_in[`IRQFE_REG_W-1:0]),
    .hw_set_in  (`IRQFE_RST_REG),
    .value_out  (enables_0_val)
  );

  // read data is captured when waitrequest drops and held to the taking edge
  always @* begin
    readdata_next = 32'h0000_0000;
    case (avs_address_in)
      `IRQFE_OFF_FLAGS_0:    readdata_next = {16'h0000, flags_0_val};
      `IRQFE_OFF_FLAGS_1:    readdata_next = {16'h0000, flags_1_val};
      `IRQFE_OFF_FLAGS_2:    readdata_next = {16'h0000, flags_2_val};
      `IRQFE_OFF_FLAGS_3:    readdata_next = {16'h0000, flags_3_val};
      `IRQFE_OFF_FLAGS_4:    readdata_next = {16'h0000, flags_4_val};
      `IRQFE_OFF_ENABLES_0:  readdata_next = {16'h0000, enables_0_val};
      `IRQFE_OFF_IRQ_STATUS: readdata_next = {27'h000_0000, irq_status_reg};
      `IRQFE_OFF_IRQ_MASK:   readdata_next = {27'h000_0000, irq_mask_reg};
      default:               readdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      readdata_reg <= 32'h0000_0000;
    end else if (bus_req & waitreq_reg) begin
      readdata_reg <= readdata_next;
    end
  end

  // one status bit per flag register, set by a new hardware request to any implemented bit of it
  assign evt_set[`IRQFE_EVT_FLAGS_0] = |(set_flags_0 & `IRQFE_IMPL_FLAGS_0);
  assign evt_set[`IRQFE_EVT_FLAGS_1] = |(set_flags_1 & `IRQFE_IMPL_FLAGS_1);
  assign evt_set[`IRQFE_EVT_FLAGS_2] = |(set_flags_2 & `IRQFE_IMPL_FLAGS_2);
  assign evt_set[`IRQFE_EVT_FLAGS_3] = |(set_flags_3 & `IRQFE_IMPL_FLAGS_3);
  assign evt_set[`IRQFE_EVT_FLAGS_4] = |(set_flags_4 & `IRQFE_IMPL_FLAGS_4);

  // clear only what the read returned, so an event arriving mid-read survives
  always @* begin
    irq_status_next = irq_status_reg;
    if (rd_take & hit_irq_status) begin
      irq_status_next = irq_status_reg & ~readdata_reg[`IRQFE_EVT_W-1:0];
    end
    irq_status_next = irq_status_next | evt_set;
  end

  always @* begin
    irq_mask_next = irq_mask_reg;
    if (wr_take & hit_irq_mask & avs_byteenable_in[0]) begin
      irq_mask_next = avs_writedata_in[`IRQFE_EVT_W-1:0];
    end
  end

  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_status_reg <= `IRQFE_RST_EVT;
      irq_mask_reg   <= `IRQFE_RST_EVT;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg   <= irq_mask_next;
      irq_reg        <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // registered to keep the output glitch free; costs one cycle of latency
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      request_reg <= {`IRQFE_FLAGS0_W{1'b0}};
    end else begin
      request_reg <= flags_0_val[`IRQFE_FLAGS0_W-1:0]
                   & enables_0_val[`IRQFE_FLAGS0_W-1:0];
    end
  end

  assign avs_readdata_out    = readdata_reg;
  assign avs_waitrequest_out = waitreq_reg;
  assign irq_out             = irq_reg;
  assign irq_flags_0_out     = flags_0_val;
  assign irq_flags_1_out     = flags_1_val;
  assign irq_flags_2_out     = flags_2_val;
  assign irq_flags_3_out     = flags_3_val;
  assign irq_flags_4_out     = flags_4_val;
  assign irq_enables_0_out   = enables_0_val;
  assign flags0_request_out  = request_reg;

endmodule // irqfe_bank

// ==== irqfe_checker.sv ====
module irqfe_checker (
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic [5:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [2:0]  src_flags0_req_in,
  input wire logic [15:0] irq_flags_0_out,
  input wire logic [15:0] irq_flags_1_out,
  input wire logic [15:0] irq_flags_2_out,
  input wire logic [15:0] irq_flags_3_out,
  input wire logic [15:0] irq_flags_4_out,
  input wire logic [15:0] irq_enables_0_out,
  input wire logic [2:0]  flags0_request_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_req_seen;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_answer;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  a_wait_answer: assert property (s_req_seen |=> s_answer)
    else $error("bus request not answered in one cycle");
  a_no_spurious: assert property ($fell(avs_waitrequest_out) |->
    $past(avs_read_in) || $past(avs_write_in))
    else $error("answer without request");
  a_upper_zero: assert property (avs_readdata_out[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_unimpl_zero: assert property ((irq_flags_0_out & 16'hfff8) == 16'h0000
    && (irq_flags_1_out & 16'h0020) == 16'h0000 && (irq_flags_2_out & 16'h9fe0) == 16'h0000
    && (irq_flags_3_out & 16'h01ff) == 16'h0000 && (irq_flags_4_out & 16'h3181) == 16'h0000)
    else $error("unimplemented flag bit set");
  a_en_bit15: assert property (!irq_enables_0_out[15])
    else $error("enable bit 15 set");
  a_req_gate: assert property (flags0_request_out ==
    ($past(irq_flags_0_out[2:0]) & $past(irq_enables_0_out[2:0])))
    else $error("request not flag and enable");
  a_hw_set: assert property ($rose(src_flags0_req_in[0]) |-> ##3 irq_flags_0_out[0])
    else $error("request edge did not set flag");
  a_clear_write: assert property ($fell(irq_flags_0_out[0]) |-> $past(avs_write_in)
    && !$past(avs_waitrequest_out) && $past(avs_address_in) == 6'h00)
    else $error("flag cleared without software write");
endmodule // irqfe_checker

// ==== irqfe_src_model.sv ====
module irqfe_src_model (
  input  wire logic  mclk_in,
  output logic [2:0]  req0_out,
  output logic [15:0] req1_out,
  output logic [15:0] req2_out,
  output logic [15:0] req3_out,
  output logic [15:0] req4_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req0_out, req1_out, req2_out, req3_out, req4_out} = '0;
  // one clean low-high-low per event, so the edge detector sets once
  task automatic pulse(input int idx, input logic [15:0] bits);
    @(posedge mclk_in);
    case (idx)
      0: req0_out <= bits[2:0];
      1: req1_out <= bits;
      2: req2_out <= bits;
      3: req3_out <= bits;
      default: req4_out <= bits;
    endcase
    repeat (3) @(posedge mclk_in);
    {req0_out, req1_out, req2_out, req3_out, req4_out} <= '0;
  endtask
endmodule // irqfe_src_model

// ==== irqfe_bank_tb.sv ====
module irqfe_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, rst_b_in, rd, wr;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata_q;
  logic [3:0]  be;
  wire  [31:0] rdata;
  wire         wait_w, irq;
  wire  [2:0]  r0, fr;
  wire  [15:0] r1, r2, r3, r4;
  wire  [15:0] fo [6];
  int          fail_count, comparisons;
  localparam logic [5:0]  OFF [6] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14};
  localparam logic [15:0] IMPL [6] = '{16'h0007, 16'hffdf, 16'h601f, 16'hfe00, 16'hce7e, 16'h7fff};

  irqfe_src_model u_irqfe_src_model (.mclk_in(mclk_in), .req0_out(r0), .req1_out(r1),
    .req2_out(r2), .req3_out(r3), .req4_out(r4));
  irqfe_bank u_irqfe_bank (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_w), .irq_out(irq),
    .src_flags0_req_in(r0), .src_flags1_req_in(r1), .src_flags2_req_in(r2),
    .src_flags3_req_in(r3), .src_flags4_req_in(r4), .irq_flags_0_out(fo[0]),
    .irq_flags_1_out(fo[1]), .irq_flags_2_out(fo[2]), .irq_flags_3_out(fo[3]),
    .irq_flags_4_out(fo[4]), .irq_enables_0_out(fo[5]), .flags0_request_out(fr));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // holds the request until waitrequest is sampled low, then one idle cycle
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= {16'h0000, d};
    be <= 4'h3;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wait_w !== 1'b0 && n < 20);
    rdata_q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_w !== 1'b0) begin
      $display("CHECK FAILED at %0t: bus answer timed out", $time);
      fail_count++;
      finish_test();
    end
    @(posedge mclk_in);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(rdata_q, {16'h0000, exp});
  endtask

  initial begin
    rst_b_in = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0000_0000;
    be = 4'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 0; i < 8; i++) rd_chk(6'(i * 4), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFF[i], 16'hffff);
      rd_chk(OFF[i], IMPL[i]);
      chk({16'h0000, fo[i]}, {16'h0000, IMPL[i]});
      bus(1'b1, OFF[i], 16'h0000);
      rd_chk(OFF[i], 16'h0000);
    end
    bus(1'b1, 6'h20, 16'hffff);
    rd_chk(6'h20, 16'h0000);
    bus(1'b1, 6'h14, 16'h0005);
    bus(1'b1, 6'h00, 16'h0007);
    repeat (2) @(posedge mclk_in);
    chk({29'h0, fr}, 32'h0000_0005);
    bus(1'b1, 6'h14, 16'h0000);
    repeat (2) @(posedge mclk_in);
    chk({29'h0, fr}, 32'h0000_0000);
    bus(1'b1, 6'h00, 16'h0000);
    bus(1'b1, 6'h1c, 16'h0002);
    bus(1'b0, 6'h18, 16'h0000);
    u_irqfe_src_model.pulse(1, 16'h2020);
    repeat (3) @(posedge mclk_in);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(6'h04, 16'h2000);
    rd_chk(6'h18, 16'h0002);
    repeat (3) @(posedge mclk_in);
    chk({31'h0, irq}, 32'h0000_0000);
    // event in a register whose status bit is masked out
    u_irqfe_src_model.pulse(2, 16'h4000);
    repeat (3) @(posedge mclk_in);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(6'h08, 16'h4000);
    rd_chk(6'h18, 16'h0004);
    bus(1'b1, 6'h04, 16'h0000);
    rd_chk(6'h04, 16'h0000);
    fork
      u_irqfe_src_model.pulse(0, 16'h0001);
      begin
        // write of zero taken on the same edge that the request sets the flag
        repeat (2) @(posedge mclk_in);
        bus(1'b1, 6'h00, 16'h0000);
      end
    join
    repeat (3) @(posedge mclk_in);
    rd_chk(6'h00, 16'h0001);
    bus(1'b1, 6'h14, 16'h1234);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    rd_chk(6'h14, 16'h0000);
    rd_chk(6'h00, 16'h0000);
    finish_test();
  end
endmodule // irqfe_bank_tb

bind irqfe_bank irqfe_checker u_irqfe_checker (.mclk_in, .rst_b_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .src_flags0_req_in,
  .irq_flags_0_out, .irq_flags_1_out, .irq_flags_2_out, .irq_flags_3_out, .irq_flags_4_out,
  .irq_enables_0_out, .flags0_request_out);
